// >>> shared/acb_pkg.sv
`default_nettype none
package acb_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // datapath width
    localparam int ACB_SAMPLE_W = 24;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] ACB_ADDR_INPUT_CONFIG   = 8'h50;
    localparam logic [7:0] ACB_ADDR_DIGITAL_VOLUME = 8'h52;
    localparam logic [7:0] ACB_ADDR_FINE_GAIN      = 8'h53;

    // reset values
    localparam logic [7:0] ACB_RST_INPUT_CONFIG    = 8'h00;
    localparam logic [7:0] ACB_RST_DIGITAL_VOLUME  = 8'ha1;
    localparam logic [7:0] ACB_RST_FINE_GAIN       = 8'h80;

    // field positions
    localparam int ACB_SRC_MSB = 7;
    localparam int ACB_SRC_LSB = 6;
    localparam int ACB_FS_BIT  = 1;
    localparam int ACB_BW_BIT  = 0;
    localparam int ACB_FG_MSB  = 7;
    localparam int ACB_FG_LSB  = 4;

    // writable bits; everything else is reserved and reads zero
    localparam logic [7:0] ACB_WMASK_INPUT_CONFIG  = 8'hc3;
    localparam logic [7:0] ACB_WMASK_FINE_GAIN     = 8'hf0;

    ////////////////////////////////////////////////////////////////////////////////
    // gain law: volume code 0 mutes, code+7 splits into octaves of 12 half-dB steps
    localparam logic [7:0] ACB_VOL_MUTE      = 8'h00;
    localparam logic [8:0] ACB_VOL_OCT_BIAS  = 9'h007;
    localparam logic [8:0] ACB_VOL_STEPS_OCT = 9'h00c;
    localparam logic [4:0] ACB_VOL_OCT_TOP   = 5'h1d;
    localparam logic [4:0] ACB_FG_RSHIFT     = 5'h0f;

    // volume mantissas, Q1.15, 0 dB to 5.5 dB in 0.5 dB steps
    localparam logic [15:0] ACB_VOL_MANT [12] = '{
        16'h8000, 16'h8796, 16'h8f9e, 16'h9821, 16'ha124, 16'haab1,
        16'hb4ce, 16'hbf85, 16'hcade, 16'hd6e4, 16'he3a0, 16'hf11c
    };

    // fine gain mantissas, Q1.15, -0.8 dB to 0.7 dB in 0.1 dB steps
    localparam logic [15:0] ACB_FG_MANT [16] = '{
        16'h74bd, 16'h7617, 16'h7775, 16'h78d7, 16'h7a3d, 16'h7ba8,
        16'h7d16, 16'h7e89, 16'h8000, 16'h817b, 16'h82fb, 16'h847f,
        16'h8608, 16'h8796, 16'h8928, 16'h8abe
    };

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        ACB_SRC_DIFFERENTIAL,
        ACB_SRC_SINGLE_ENDED,
        ACB_SRC_UNUSED2,
        ACB_SRC_UNUSED3
    } acb_src_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acb_reg_req_t;

    typedef struct packed {
        logic                           valid;
        logic signed [ACB_SAMPLE_W-1:0] data;
    } acb_sample_t;

endpackage
`default_nettype wire

// >>> logic/acb_scale.sv
`timescale 1ns/10ps
`default_nettype none
module acb_scale #(
    parameter int W = 24
) (
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    input  wire logic                i_valid,
    input  wire logic signed [W-1:0] i_data,
    input  wire logic [15:0]         i_coef,
    input  wire logic [4:0]          i_rshift,
    input  wire logic                i_zero,
    output var  logic                o_valid,
    output var  logic signed [W-1:0] o_data
);

    ////////////////////////////////////////////////////////////////////////////////
    // product scaled by 2^-rshift, saturated back to W bits
    localparam logic signed [W+16:0] MAX_V = {18'h00000, {(W-1){1'b1}}};
    localparam logic signed [W+16:0] MIN_V = ~MAX_V;

    wire logic signed [W+16:0] prod;
    wire logic signed [W+16:0] shifted;
    wire logic signed [W-1:0]  sat;

    assign prod    = i_data * $signed({1'b0, i_coef});
    assign shifted = prod >>> i_rshift;
    assign sat     = (shifted > MAX_V) ? MAX_V[W-1:0] :
                     (shifted < MIN_V) ? MIN_V[W-1:0] : shifted[W-1:0];

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_valid <= 1'b0;
            o_data  <= '0;
        end else begin
            o_valid <= i_valid;
            o_data  <= i_zero ? '0 : sat;
        end
    end

endmodule
`default_nettype wire

// >>> logic/acb_config_bank.sv
// Behaviour
// - The two-bit input source field at bits 7-6 of the input config register selects differential input for code 0 and single-ended for code 1, and codes 2 and 3 are not to be used.
// - The full-scale bit selects a 10 Vrms differential range when clear and 5 Vrms when set.
// - The bandwidth bit selects 24 kHz audio bandwidth when clear and 96 kHz wide bandwidth when set.
// - A digital volume code of zero mutes the channel output completely.
// - Volume code 1 gives -80 dB and each further code adds 0.5 dB.
// - Volume code 161 gives 0 dB and code 255 gives the maximum of 47 dB.
// - The digital volume register uses all eight bits, is read-write and resets to 0xa1.
// - The fine gain field in the upper nibble steps 0.1 dB from -0.8 dB at code 0 to 0.7 dB at 15.
// - The fine gain field resets to 8, so the register reads 0x80 and applies no correction.
// - The input config register sits at 0x50 and resets to 0x00.
`timescale 1ns/10ps
`default_nettype none
module acb_config_bank
    import acb_pkg::*;
#(
    parameter int SAMPLE_W = ACB_SAMPLE_W
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst,
    input  wire acb_reg_req_t               i_reg,
    input  wire logic                       i_sample_valid,
    input  wire logic signed [SAMPLE_W-1:0] i_sample_data,
    output var  logic [7:0]                 o_rd_data,
    output var  logic                       o_rd_valid,
    output var  acb_src_t                   o_input_source,
    output var  logic                       o_full_scale_select,
    output var  logic                       o_bandwidth_select,
    output var  logic [7:0]                 o_digital_volume,
    output var  logic [3:0]                 o_fine_gain,
    output var  logic                       o_sample_valid,
    output var  logic signed [SAMPLE_W-1:0] o_sample_data
);

    ////////////////////////////////////////////////////////////////////////////////
    // address decode

    wire logic sel_cfg;
    wire logic sel_vol;
    wire logic sel_fg;
    wire logic wr_cfg;
    wire logic wr_vol;
    wire logic wr_fg;

    assign sel_cfg = (i_reg.addr == ACB_ADDR_INPUT_CONFIG);
    assign sel_vol = (i_reg.addr == ACB_ADDR_DIGITAL_VOLUME);
    assign sel_fg  = (i_reg.addr == ACB_ADDR_FINE_GAIN);
    assign wr_cfg  = i_reg.wr & sel_cfg;
    assign wr_vol  = i_reg.wr & sel_vol;
    assign wr_fg   = i_reg.wr & sel_fg;

    ////////////////////////////////////////////////////////////////////////////////
    // register storage; only writable bits are held, reserved ones stay zero

    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic [7:0] vol_q;
    logic [7:0] vol_d;
    logic [7:0] fg_q;
    logic [7:0] fg_d;

    // stray ones in reserved positions are dropped so they never read back
    assign cfg_d = wr_cfg ? (i_reg.wdata & ACB_WMASK_INPUT_CONFIG) : cfg_q;
    assign vol_d = wr_vol ? i_reg.wdata : vol_q;
    assign fg_d  = wr_fg  ? (i_reg.wdata & ACB_WMASK_FINE_GAIN) : fg_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cfg_q <= ACB_RST_INPUT_CONFIG;
            vol_q <= ACB_RST_DIGITAL_VOLUME;
            fg_q  <= ACB_RST_FINE_GAIN;
        end else begin
            cfg_q <= cfg_d;
            vol_q <= vol_d;
            fg_q  <= fg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read port; unmapped offsets return zero

    logic [7:0] rd_data_q;
    logic       rd_valid_q;
    wire  logic [7:0] rd_mux;

    assign rd_mux = sel_cfg ? cfg_q :
                    sel_vol ? vol_q :
                    sel_fg  ? fg_q  : 8'h00;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_data_q  <= i_reg.rd ? rd_mux : 8'h00;
            rd_valid_q <= i_reg.rd;
        end
    end

    assign o_rd_data  = rd_data_q;
    assign o_rd_valid = rd_valid_q;

    ////////////////////////////////////////////////////////////////////////////////
    // analog front end controls, straight from the register bits

    // codes 2 and 3 are passed on unchanged; the front end treats them as unused
    assign o_input_source      = acb_src_t'(cfg_q[ACB_SRC_MSB:ACB_SRC_LSB]);
    assign o_full_scale_select = cfg_q[ACB_FS_BIT];
    assign o_bandwidth_select  = cfg_q[ACB_BW_BIT];
    assign o_digital_volume    = vol_q;
    assign o_fine_gain         = fg_q[ACB_FG_MSB:ACB_FG_LSB];

    ////////////////////////////////////////////////////////////////////////////////
    // volume law: code+7 = 12*octave + step, gain = mant[step] * 2^(octave-14)
    // so code 1 lands at -80 dB, code 161 at unity and code 255 at 47 dB;
    // an octave is taken as exactly x2, so far codes drift a few tenths of a dB

    wire logic [8:0]  vol_idx;
    wire logic [8:0]  vol_oct_w;
    wire logic [8:0]  vol_rem_w;
    wire logic [4:0]  vol_oct;
    wire logic [3:0]  vol_rem;
    wire logic [15:0] vol_coef;
    wire logic [4:0]  vol_rshift;
    wire logic        vol_mute;

    assign vol_idx    = {1'b0, vol_q} + ACB_VOL_OCT_BIAS;
    assign vol_oct_w  = vol_idx / ACB_VOL_STEPS_OCT;
    assign vol_rem_w  = vol_idx % ACB_VOL_STEPS_OCT;
    assign vol_oct    = vol_oct_w[4:0];
    assign vol_rem    = vol_rem_w[3:0];
    assign vol_coef   = ACB_VOL_MANT[vol_rem];
    assign vol_rshift = ACB_VOL_OCT_TOP - vol_oct;
    assign vol_mute   = (vol_q == ACB_VOL_MUTE);

    ////////////////////////////////////////////////////////////////////////////////
    // fine gain law: a 16-entry table around unity at code 8

    wire logic [15:0] fg_coef;

    assign fg_coef = ACB_FG_MANT[fg_q[ACB_FG_MSB:ACB_FG_LSB]];

    ////////////////////////////////////////////////////////////////////////////////
    // sample path: volume stage then fine gain stage, one cycle each

    logic                       vol_valid;
    logic signed [SAMPLE_W-1:0] vol_data;

    // mute forces zero rather than the largest attenuation
    acb_scale #(
        .W        (SAMPLE_W)
    ) u_volume (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_valid  (i_sample_valid),
        .i_data   (i_sample_data),
        .i_coef   (vol_coef),
        .i_rshift (vol_rshift),
        .i_zero   (vol_mute),
        .o_valid  (vol_valid),
        .o_data   (vol_data)
    );

    acb_scale #(
        .W        (SAMPLE_W)
    ) u_fine_gain (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_valid  (vol_valid),
        .i_data   (vol_data),
        .i_coef   (fg_coef),
        .i_rshift (ACB_FG_RSHIFT),
        .i_zero   (1'b0),
        .o_valid  (o_sample_valid),
        .o_data   (o_sample_data)
    );

endmodule
`default_nettype wire

// >>> tb/acb_config_bank_checker.sv
`timescale 1ns/10ps
`default_nettype none
module acb_config_bank_checker
    import acb_pkg::*;
#(
    parameter int SAMPLE_W = ACB_SAMPLE_W
) (
    input wire logic                       i_clk,
    input wire logic                       i_rst,
    input wire acb_reg_req_t               i_reg,
    input wire logic                       i_sample_valid,
    input wire logic signed [SAMPLE_W-1:0] i_sample_data,
    input wire logic [7:0]                 o_rd_data,
    input wire logic                       o_rd_valid,
    input wire acb_src_t                   o_input_source,
    input wire logic                       o_full_scale_select,
    input wire logic                       o_bandwidth_select,
    input wire logic [7:0]                 o_digital_volume,
    input wire logic [3:0]                 o_fine_gain,
    input wire logic                       o_sample_valid,
    input wire logic signed [SAMPLE_W-1:0] o_sample_data
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire logic w_cfg = i_reg.wr && i_reg.addr == ACB_ADDR_INPUT_CONFIG;
    wire logic w_vol = i_reg.wr && i_reg.addr == ACB_ADDR_DIGITAL_VOLUME;
    wire logic w_fg  = i_reg.wr && i_reg.addr == ACB_ADDR_FINE_GAIN;
    wire logic w_map = i_reg.addr inside {8'h50, 8'h52, 8'h53};
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_smp; i_sample_valid ##2 1'b1; endsequence
    sequence s_mute; i_sample_valid && o_digital_volume == ACB_VOL_MUTE ##2 1'b1; endsequence
    property p_rd_valid; i_reg.rd |=> o_rd_valid; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read valid missing");
    property p_rd_unmapped; i_reg.rd && !w_map |=> o_rd_data == 8'h00; endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
    property p_rd_vol;
        i_reg.rd && !i_reg.wr && i_reg.addr == 8'h52 |=> o_rd_data == o_digital_volume;
    endproperty
    a_rd_vol: assert property (p_rd_vol) else $error("volume readback");
    property p_cfg_wr; w_cfg |=> {o_input_source, o_full_scale_select, o_bandwidth_select}
        == {$past(i_reg.wdata[7:6]), $past(i_reg.wdata[1:0])}; endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("config write");
    property p_fg_wr; w_fg |=> o_fine_gain == $past(i_reg.wdata[7:4]); endproperty
    a_fg_wr: assert property (p_fg_wr) else $error("fine gain write");
    // a reset cycle reloads the volume, so it is no hold cycle
    property p_vol_hold; !w_vol && !i_rst |=> $stable(o_digital_volume); endproperty
    a_vol_hold: assert property (p_vol_hold) else $error("volume changed");
    property p_smp; s_smp |-> o_sample_valid; endproperty
    a_smp: assert property (p_smp) else $error("sample valid late");
    property p_mute; s_mute |-> o_sample_valid && o_sample_data == '0; endproperty
    a_mute: assert property (p_mute) else $error("mute not zero");
endmodule
bind acb_config_bank acb_config_bank_checker #(.SAMPLE_W(SAMPLE_W)) chk_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_reg(i_reg), .i_sample_valid(i_sample_valid),
    .i_sample_data(i_sample_data), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_input_source(o_input_source), .o_full_scale_select(o_full_scale_select),
    .o_bandwidth_select(o_bandwidth_select), .o_digital_volume(o_digital_volume),
    .o_fine_gain(o_fine_gain), .o_sample_valid(o_sample_valid), .o_sample_data(o_sample_data));
`default_nettype wire

// >>> tb/adc_channel1_config_bank_test.sv
`timescale 1ns/10ps
`default_nettype none
module adc_channel1_config_bank_test;
    import acb_pkg::*;
    localparam int SW = ACB_SAMPLE_W;
    localparam logic [7:0] ADDRS [5] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'hff};
    localparam logic [7:0] VOLS [7] = '{8'h00, 8'h01, 8'h02, 8'ha1, 8'ha2, 8'hfe, 8'hff};
    logic                 i_clk = 1'b0;
    logic                 i_rst, smp_v, rd_valid, fs, bw, o_v;
    acb_reg_req_t         req;
    acb_src_t             src;
    logic signed [SW-1:0] smp_d, o_d;
    logic [7:0]           rd_data, vol, m_cfg, m_vol, m_fg;
    logic [3:0]           fg;
    logic [31:0]          seed;
    int                   mismatches, checked;
    acb_config_bank #(.SAMPLE_W(SW)) acb_config_bank_i (.i_clk(i_clk), .i_rst(i_rst),
        .i_reg(req), .i_sample_valid(smp_v), .i_sample_data(smp_d), .o_rd_data(rd_data),
        .o_rd_valid(rd_valid), .o_input_source(src), .o_full_scale_select(fs),
        .o_bandwidth_select(bw), .o_digital_volume(vol), .o_fine_gain(fg),
        .o_sample_valid(o_v), .o_sample_data(o_d));
    always #2 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // volume code 0 mutes, otherwise half-dB steps, then 0.1 dB fine gain, both saturated
    function automatic longint gain(longint x, int v, int f);
        longint y;
        longint lim;
        int     idx;
        lim = longint'(1) <<< (SW - 1);
        if (v == 0) return 0;
        idx = v + 7;
        y = (x * longint'(ACB_VOL_MANT[idx % 12])) >>> (29 - idx / 12);
        y = (y > lim - 1) ? lim - 1 : (y < -lim) ? -lim : y;
        y = (y * longint'(ACB_FG_MANT[f])) >>> 15;
        return (y > lim - 1) ? lim - 1 : (y < -lim) ? -lim : y;
    endfunction
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (mismatches == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        req <= '0;
        if (a == 8'h50) m_cfg = d & 8'hc3;
        if (a == 8'h52) m_vol = d;
        if (a == 8'h53) m_fg = d & 8'hf0;
        @(posedge i_clk);
    endtask
    task automatic rd(logic [7:0] a);
        logic [7:0] e;
        e = (a == 8'h50) ? m_cfg : (a == 8'h52) ? m_vol : (a == 8'h53) ? m_fg : 8'h00;
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk);
        req <= '0;
        @(negedge i_clk);
        chk("rd_valid", rd_valid, 1);
        chk("rd_data", rd_data, e);
        chk("input_source", src, m_cfg[7:6]);
        chk("full_scale", fs, m_cfg[1]);
        chk("bandwidth", bw, m_cfg[0]);
        chk("volume", vol, m_vol);
        chk("fine_gain", fg, m_fg[7:4]);
        @(posedge i_clk);
    endtask
    task automatic smp(logic signed [SW-1:0] x);
        longint e;
        e = gain(x, m_vol, m_fg[7:4]);
        smp_v <= 1'b1;
        smp_d <= x;
        @(posedge i_clk);
        smp_v <= 1'b0;
        @(posedge i_clk);
        @(negedge i_clk);
        chk("smp_valid", o_v, 1);
        chk("smp_data", 32'(o_d), e[31:0]);
        @(posedge i_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge i_clk);
        mismatches++;
        complete_run();
    end
    initial begin
        i_rst = 1;
        req = '0;
        smp_v = 0;
        smp_d = '0;
        seed = 32'hde24;
        {m_cfg, m_vol, m_fg} = {8'h00, 8'ha1, 8'h80};
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int k = 0; k < 5; k++) rd(ADDRS[k]);
        // source codes 2 and 3 and ones in reserved bits are never written
        for (int s = 0; s < 4; s++) begin
            wr(8'h50, {1'b0, s[0], 4'h0, s[1:0]});
            rd(8'h50);
        end
        wr(8'h51, 8'h5a);
        rd(8'h51);
        wr(8'h53, 8'hf0);
        rd(8'h53);
        for (int i = 0; i < 8; i++) begin
            for (int j = 0; j < 3; j++) begin
                seed = lfsr(seed);
                wr(8'h52, (i == 7) ? seed[31:24] : VOLS[i]);
                wr(8'h53, {(j == 0) ? 4'h0 : (j == 1) ? 4'h8 : 4'hf, 4'h0});
                smp(seed[23:0]);
                smp((j == 2) ? 24'h800000 : 24'h7fffff);
            end
        end
        i_rst <= 1'b1;
        @(posedge i_clk);
        i_rst <= 1'b0;
        {m_cfg, m_vol, m_fg} = {8'h00, 8'ha1, 8'h80};
        rd(8'h52);
        smp(24'h123456);
        complete_run();
    end
endmodule
`default_nettype wire
